// file: logic/bps_pkg.sv
`default_nettype none
package bps_pkg;
  // register byte addresses on the bus
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_OUT_EN = 8'h04;
  localparam logic [7:0] OFF_PDATA_A = 8'h08;
  localparam logic [7:0] OFF_PDIR_A = 8'h0C;
  localparam logic [7:0] OFF_PDATA_B = 8'h10;
  localparam logic [7:0] OFF_PDIR_B = 8'h14;
  localparam logic [7:0] OFF_LEVEL_A = 8'h18;
  localparam logic [7:0] OFF_LEVEL_B = 8'h1C;
  // mode register fields
  localparam int MODE_EXT_BIT = 0;
  localparam int MODE_BUS8_BIT = 1;
  localparam int MODE_AHI_OFF_BIT = 2;
  localparam int MODE_ATOP_OFF_BIT = 3;
  localparam logic [31:0] MODE_MASK = 32'h0000_000F;
  // output enable fields
  localparam int OE_TMR_LSB = 0;
  localparam int OE_CMP_LSB = 4;
  localparam int OE_PG_LSB = 12;
  localparam logic [31:0] OUT_EN_MASK = 32'h0003_FFFF;
  // port group bank a and bank b layout
  localparam int A_TWO_LSB = 0;
  localparam int A_THREE_LSB = 8;
  localparam int A_FOUR_LSB = 16;
  localparam int A_FIVE_LSB = 24;
  localparam logic [31:0] A_MASK = 32'hFFFF_FFFF;
  localparam int B_SIX_LSB = 0;
  localparam int B_SIX_HI_LSB = 5;
  localparam int B_CMP_LSB = 8;
  localparam int B_TMR_LSB = 16;
  localparam int B_PG_LSB = 24;
  localparam logic [31:0] B_MASK = 32'h3F0F_FFFF;
  // group widths
  localparam int W_BYTE = 8;
  localparam int W_AHI = 5;
  localparam int W_ATOP = 3;
  localparam int W_TMR = 4;
  localparam int W_CMP = 8;
  localparam int W_PG = 6;
  // reset values: single-chip, all peripherals off, ports input
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [31:0] OUT_EN_RST = 32'h0000_0000;
  localparam logic [31:0] PORT_RST = 32'h0000_0000;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// file: logic/bps_slice_if.sv
`timescale 1ns/1ps
`default_nettype none
// one pin group between the control logic and its slice
interface bps_slice_if #(parameter int W = 8);
  logic [W-1:0] func_sel;
  logic [W-1:0] func_out;
  logic [W-1:0] func_drive;
  logic [W-1:0] port_dout;
  logic [W-1:0] port_dir;
  logic [W-1:0] pin_in;
  logic [W-1:0] pin_out;
  logic [W-1:0] pin_oe_n;
  logic [W-1:0] level;
  modport ctrl (output func_sel, func_out, func_drive, port_dout, port_dir, pin_in,
                input pin_out, pin_oe_n, level);
  modport slice (input func_sel, func_out, func_drive, port_dout, port_dir, pin_in,
                 output pin_out, pin_oe_n, level);
endinterface
`default_nettype wire

// file: logic/bps_pin_slice.sv
`timescale 1ns/1ps
`default_nettype none
module bps_pin_slice #(
  parameter int W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  bps_slice_if.slice sl
);
  logic [W-1:0] sync1_q, sync2_q, sync3_q, level_q, out_q, oe_n_q;
  logic [W-1:0] out_d, oe_n_d, level_d;

  // per-bit choice; port mode never looks at the function side
  // port data select
  assign out_d = (sl.func_sel & sl.func_out) | (~sl.func_sel & sl.port_dout);
  assign oe_n_d = ~((sl.func_sel & sl.func_drive) | (~sl.func_sel & sl.port_dir));
  // level moves only once two late stages agree, filtering metastable glitches
  assign level_d = (sync2_q & ~(sync2_q ^ sync3_q)) | (level_q & (sync2_q ^ sync3_q));

  // registered pad drive, released during reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_q <= '0;
      oe_n_q <= '1;
    end else begin
      out_q <= out_d;
      oe_n_q <= oe_n_d;
    end
  end

  // three-stage input synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      level_q <= '0;
    end else begin
      sync1_q <= sl.pin_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      level_q <= level_d;
    end
  end

  assign sl.pin_out = out_q;
  assign sl.pin_oe_n = oe_n_q;
  assign sl.level = level_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_port_value;
    1 |=> ((out_q ^ $past(sl.port_dout)) & $past(~sl.func_sel)) == '0;
  endproperty
  a_port_value: assert property (p_port_value) else $error("port pin value wrong");

  property p_port_dir;
    1 |=> ((oe_n_q ^ ~$past(sl.port_dir)) & $past(~sl.func_sel)) == '0;
  endproperty
  a_port_dir: assert property (p_port_dir) else $error("port pin direction wrong");
endmodule // bps_pin_slice
`default_nettype wire

// file: logic/bps_pin_share.sv
`timescale 1ns/1ps
`default_nettype none
module bps_pin_share (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [23:0] ext_addr,
  input wire logic [15:0] ext_wdata,
  input wire logic ext_wdata_drive,
  output logic [15:0] ext_rdata,
  input wire logic [3:0] reload_timer_out,
  input wire logic [7:0] compare_out,
  input wire logic [5:0] pulse_gen_out,
  input wire logic [7:0] data_hi_low_byte_pad_val,
  output logic [7:0] data_hi_low_byte_pad_drv,
  output logic [7:0] data_hi_low_byte_pad_oe_n,
  input wire logic [7:0] data_top_byte_pad_val,
  output logic [7:0] data_top_byte_pad_drv,
  output logic [7:0] data_top_byte_pad_oe_n,
  input wire logic [7:0] addr_byte0_pad_val,
  output logic [7:0] addr_byte0_pad_drv,
  output logic [7:0] addr_byte0_pad_oe_n,
  input wire logic [7:0] addr_byte1_pad_val,
  output logic [7:0] addr_byte1_pad_drv,
  output logic [7:0] addr_byte1_pad_oe_n,
  input wire logic [4:0] addr_upper_low_pad_val,
  output logic [4:0] addr_upper_low_pad_drv,
  output logic [4:0] addr_upper_low_pad_oe_n,
  input wire logic [2:0] addr_upper_high_pad_val,
  output logic [2:0] addr_upper_high_pad_drv,
  output logic [2:0] addr_upper_high_pad_oe_n,
  input wire logic [3:0] port_group_timer_pad_val,
  output logic [3:0] port_group_timer_pad_drv,
  output logic [3:0] port_group_timer_pad_oe_n,
  input wire logic [7:0] port_group_compare_pad_val,
  output logic [7:0] port_group_compare_pad_drv,
  output logic [7:0] port_group_compare_pad_oe_n,
  input wire logic [5:0] port_group_pulse_pad_val,
  output logic [5:0] port_group_pulse_pad_drv,
  output logic [5:0] port_group_pulse_pad_oe_n
);
  logic [31:0] mode_q, outen_q, pdata_a_q, pdir_a_q, pdata_b_q, pdir_b_q;
  logic [31:0] mode_d, outen_d, pdata_a_d, pdir_a_d, pdata_b_d, pdir_b_d;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q, rdata_d, rd_word, level_a, level_b;
  logic [3:0] wstrb_q;
  logic aw_got_q, w_got_q, bvalid_q, rvalid_q, awready_q, wready_q, arready_q;
  logic aw_got_d, w_got_d, bvalid_d, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;

  // byte-lane merge under the writable-bit mask
  function automatic logic [31:0] merge_wr(input logic [31:0] old, input logic [31:0] val,
                                           input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] bm;
    bm = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
    return (old & ~bm) | (val & bm);
  endfunction

  // write channel handshakes; address and data may arrive in either order
  wire aw_hs = s_axi_awvalid & awready_q;
  wire w_hs = s_axi_wvalid & wready_q;
  wire aw_have = aw_got_q | aw_hs;
  wire w_have = w_got_q | w_hs;
  wire do_write = aw_have & w_have & ~bvalid_q;
  wire [7:0] wr_addr = aw_hs ? s_axi_awaddr : awaddr_q;
  wire [31:0] wr_data = w_hs ? s_axi_wdata : wdata_q;
  wire [3:0] wr_strb = w_hs ? s_axi_wstrb : wstrb_q;
  assign aw_got_d = aw_have & ~do_write;
  assign w_got_d = w_have & ~do_write;
  assign bvalid_d = do_write | (bvalid_q & ~s_axi_bready);

  // write address decode; level registers are read-only
  wire wr_mode = do_write & (wr_addr == bps_pkg::OFF_MODE);
  wire wr_outen = do_write & (wr_addr == bps_pkg::OFF_OUT_EN);
  wire wr_pda = do_write & (wr_addr == bps_pkg::OFF_PDATA_A);
  wire wr_pra = do_write & (wr_addr == bps_pkg::OFF_PDIR_A);
  wire wr_pdb = do_write & (wr_addr == bps_pkg::OFF_PDATA_B);
  wire wr_prb = do_write & (wr_addr == bps_pkg::OFF_PDIR_B);
  wire wr_hit = wr_mode | wr_outen | wr_pda | wr_pra | wr_pdb | wr_prb;
  assign bresp_d = do_write ? (wr_hit ? bps_pkg::RESP_OKAY : bps_pkg::RESP_SLVERR) : bresp_q;

  // register next values
  assign mode_d = wr_mode ? merge_wr(mode_q, wr_data, wr_strb, bps_pkg::MODE_MASK) : mode_q;
  assign outen_d = wr_outen ? merge_wr(outen_q, wr_data, wr_strb, bps_pkg::OUT_EN_MASK) : outen_q;
  assign pdata_a_d = wr_pda ? merge_wr(pdata_a_q, wr_data, wr_strb, bps_pkg::A_MASK) : pdata_a_q;
  assign pdir_a_d = wr_pra ? merge_wr(pdir_a_q, wr_data, wr_strb, bps_pkg::A_MASK) : pdir_a_q;
  assign pdata_b_d = wr_pdb ? merge_wr(pdata_b_q, wr_data, wr_strb, bps_pkg::B_MASK) : pdata_b_q;
  assign pdir_b_d = wr_prb ? merge_wr(pdir_b_q, wr_data, wr_strb, bps_pkg::B_MASK) : pdir_b_q;

  // read decode; unmapped reads return zero with an error
  wire ar_hs = s_axi_arvalid & arready_q;
  wire rd_mode = s_axi_araddr == bps_pkg::OFF_MODE;
  wire rd_outen = s_axi_araddr == bps_pkg::OFF_OUT_EN;
  wire rd_pda = s_axi_araddr == bps_pkg::OFF_PDATA_A;
  wire rd_pra = s_axi_araddr == bps_pkg::OFF_PDIR_A;
  wire rd_pdb = s_axi_araddr == bps_pkg::OFF_PDATA_B;
  wire rd_prb = s_axi_araddr == bps_pkg::OFF_PDIR_B;
  wire rd_lva = s_axi_araddr == bps_pkg::OFF_LEVEL_A;
  wire rd_lvb = s_axi_araddr == bps_pkg::OFF_LEVEL_B;
  wire rd_hit = rd_mode | rd_outen | rd_pda | rd_pra | rd_pdb | rd_prb | rd_lva | rd_lvb;
  assign rd_word = ({32{rd_mode}} & mode_q) | ({32{rd_outen}} & outen_q) |
                   ({32{rd_pda}} & pdata_a_q) | ({32{rd_pra}} & pdir_a_q) |
                   ({32{rd_pdb}} & pdata_b_q) | ({32{rd_prb}} & pdir_b_q) |
                   ({32{rd_lva}} & level_a) | ({32{rd_lvb}} & level_b);
  assign rdata_d = ar_hs ? rd_word : rdata_q;
  assign rresp_d = ar_hs ? (rd_hit ? bps_pkg::RESP_OKAY : bps_pkg::RESP_SLVERR) : rresp_q;
  assign rvalid_d = ar_hs | (rvalid_q & ~s_axi_rready);

  // bus handshake state; readies drop while a response is pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      bvalid_q <= bvalid_d;
      rvalid_q <= rvalid_d;
      awready_q <= ~aw_got_d & ~bvalid_d;
      wready_q <= ~w_got_d & ~bvalid_d;
      arready_q <= ~rvalid_d;
    end
  end

  // held request payloads and responses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      rdata_q <= 32'h0000_0000;
      bresp_q <= bps_pkg::RESP_OKAY;
      rresp_q <= bps_pkg::RESP_OKAY;
    end else begin
      awaddr_q <= wr_addr;
      wdata_q <= wr_data;
      wstrb_q <= wr_strb;
      rdata_q <= rdata_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
    end
  end

  // control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= bps_pkg::MODE_RST;
      outen_q <= bps_pkg::OUT_EN_RST;
      pdata_a_q <= bps_pkg::PORT_RST;
      pdir_a_q <= bps_pkg::PORT_RST;
      pdata_b_q <= bps_pkg::PORT_RST;
      pdir_b_q <= bps_pkg::PORT_RST;
    end else begin
      mode_q <= mode_d;
      outen_q <= outen_d;
      pdata_a_q <= pdata_a_d;
      pdir_a_q <= pdir_a_d;
      pdata_b_q <= pdata_b_d;
      pdir_b_q <= pdir_b_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // mode decode; the mode bit changes pins on the next edge, so software
  // must quiesce the bus side before flipping it
  wire ext_mode = mode_q[bps_pkg::MODE_EXT_BIT];
  wire bus8_mode = mode_q[bps_pkg::MODE_BUS8_BIT];
  wire ahi_off = mode_q[bps_pkg::MODE_AHI_OFF_BIT];
  wire atop_off = mode_q[bps_pkg::MODE_ATOP_OFF_BIT];
  wire sel_two = ext_mode & ~bus8_mode;
  wire sel_low = ext_mode & ~ahi_off;
  wire sel_high = ext_mode & ~atop_off;

  bps_slice_if #(.W(8)) if_two();
  bps_slice_if #(.W(8)) if_three();
  bps_slice_if #(.W(8)) if_four();
  bps_slice_if #(.W(8)) if_five();
  bps_slice_if #(.W(5)) if_low();
  bps_slice_if #(.W(3)) if_high();
  bps_slice_if #(.W(4)) if_tmr();
  bps_slice_if #(.W(8)) if_cmp();
  bps_slice_if #(.W(6)) if_pg();

  assign if_two.func_sel = {8{sel_two}};
  assign if_two.func_out = ext_wdata[7:0];
  assign if_two.func_drive = {8{ext_wdata_drive}};
  assign if_two.port_dout = pdata_a_q[bps_pkg::A_TWO_LSB +: bps_pkg::W_BYTE];
  assign if_two.port_dir = pdir_a_q[bps_pkg::A_TWO_LSB +: bps_pkg::W_BYTE];
  assign if_two.pin_in = data_hi_low_byte_pad_val;
  assign if_three.func_sel = {8{ext_mode}};
  assign if_three.func_out = ext_wdata[15:8];
  assign if_three.func_drive = {8{ext_wdata_drive}};
  assign if_three.port_dout = pdata_a_q[bps_pkg::A_THREE_LSB +: bps_pkg::W_BYTE];
  assign if_three.port_dir = pdir_a_q[bps_pkg::A_THREE_LSB +: bps_pkg::W_BYTE];
  assign if_three.pin_in = data_top_byte_pad_val;
  assign if_four.func_sel = {8{ext_mode}};
  assign if_four.func_out = ext_addr[7:0];
  assign if_four.func_drive = '1;
  assign if_four.port_dout = pdata_a_q[bps_pkg::A_FOUR_LSB +: bps_pkg::W_BYTE];
  assign if_four.port_dir = pdir_a_q[bps_pkg::A_FOUR_LSB +: bps_pkg::W_BYTE];
  assign if_four.pin_in = addr_byte0_pad_val;
  assign if_five.func_sel = {8{ext_mode}};
  assign if_five.func_out = ext_addr[15:8];
  assign if_five.func_drive = '1;
  assign if_five.port_dout = pdata_a_q[bps_pkg::A_FIVE_LSB +: bps_pkg::W_BYTE];
  assign if_five.port_dir = pdir_a_q[bps_pkg::A_FIVE_LSB +: bps_pkg::W_BYTE];
  assign if_five.pin_in = addr_byte1_pad_val;
  assign if_low.func_sel = {5{sel_low}};
  assign if_low.func_out = ext_addr[20:16];
  assign if_low.func_drive = '1;
  assign if_low.port_dout = pdata_b_q[bps_pkg::B_SIX_LSB +: bps_pkg::W_AHI];
  assign if_low.port_dir = pdir_b_q[bps_pkg::B_SIX_LSB +: bps_pkg::W_AHI];
  assign if_low.pin_in = addr_upper_low_pad_val;
  assign if_high.func_sel = {3{sel_high}};
  assign if_high.func_out = ext_addr[23:21];
  assign if_high.func_drive = '1;
  assign if_high.port_dout = pdata_b_q[bps_pkg::B_SIX_HI_LSB +: bps_pkg::W_ATOP];
  assign if_high.port_dir = pdir_b_q[bps_pkg::B_SIX_HI_LSB +: bps_pkg::W_ATOP];
  assign if_high.pin_in = addr_upper_high_pad_val;
  assign if_tmr.func_sel = outen_q[bps_pkg::OE_TMR_LSB +: bps_pkg::W_TMR];
  assign if_tmr.func_out = reload_timer_out;
  assign if_tmr.func_drive = '1;
  assign if_tmr.port_dout = pdata_b_q[bps_pkg::B_TMR_LSB +: bps_pkg::W_TMR];
  assign if_tmr.port_dir = pdir_b_q[bps_pkg::B_TMR_LSB +: bps_pkg::W_TMR];
  assign if_tmr.pin_in = port_group_timer_pad_val;
  assign if_cmp.func_sel = outen_q[bps_pkg::OE_CMP_LSB +: bps_pkg::W_CMP];
  assign if_cmp.func_out = compare_out;
  assign if_cmp.func_drive = '1;
  assign if_cmp.port_dout = pdata_b_q[bps_pkg::B_CMP_LSB +: bps_pkg::W_CMP];
  assign if_cmp.port_dir = pdir_b_q[bps_pkg::B_CMP_LSB +: bps_pkg::W_CMP];
  assign if_cmp.pin_in = port_group_compare_pad_val;
  assign if_pg.func_sel = outen_q[bps_pkg::OE_PG_LSB +: bps_pkg::W_PG];
  assign if_pg.func_out = pulse_gen_out;
  assign if_pg.func_drive = '1;
  assign if_pg.port_dout = pdata_b_q[bps_pkg::B_PG_LSB +: bps_pkg::W_PG];
  assign if_pg.port_dir = pdir_b_q[bps_pkg::B_PG_LSB +: bps_pkg::W_PG];
  assign if_pg.pin_in = port_group_pulse_pad_val;

  // one slice per pin group
  bps_pin_slice #(.W(8)) u_two (.aclk(aclk), .aresetn(aresetn), .sl(if_two.slice));
  bps_pin_slice #(.W(8)) u_three (.aclk(aclk), .aresetn(aresetn), .sl(if_three.slice));
  bps_pin_slice #(.W(8)) u_four (.aclk(aclk), .aresetn(aresetn), .sl(if_four.slice));
  bps_pin_slice #(.W(8)) u_five (.aclk(aclk), .aresetn(aresetn), .sl(if_five.slice));
  bps_pin_slice #(.W(5)) u_low (.aclk(aclk), .aresetn(aresetn), .sl(if_low.slice));
  bps_pin_slice #(.W(3)) u_high (.aclk(aclk), .aresetn(aresetn), .sl(if_high.slice));
  bps_pin_slice #(.W(4)) u_tmr (.aclk(aclk), .aresetn(aresetn), .sl(if_tmr.slice));
  bps_pin_slice #(.W(8)) u_cmp (.aclk(aclk), .aresetn(aresetn), .sl(if_cmp.slice));
  bps_pin_slice #(.W(6)) u_pg (.aclk(aclk), .aresetn(aresetn), .sl(if_pg.slice));

  // synchronised pin levels; bus read data is only as fresh as the synchroniser
  assign level_a = {if_five.level, if_four.level, if_three.level, if_two.level};
  assign level_b = {2'h0, if_pg.level, 4'h0, if_tmr.level, if_cmp.level, if_high.level, if_low.level};
  assign ext_rdata = {if_three.level, if_two.level};

  // pad outputs straight from slice flip-flops
  assign data_hi_low_byte_pad_drv = if_two.pin_out;
  assign data_hi_low_byte_pad_oe_n = if_two.pin_oe_n;
  assign data_top_byte_pad_drv = if_three.pin_out;
  assign data_top_byte_pad_oe_n = if_three.pin_oe_n;
  assign addr_byte0_pad_drv = if_four.pin_out;
  assign addr_byte0_pad_oe_n = if_four.pin_oe_n;
  assign addr_byte1_pad_drv = if_five.pin_out;
  assign addr_byte1_pad_oe_n = if_five.pin_oe_n;
  assign addr_upper_low_pad_drv = if_low.pin_out;
  assign addr_upper_low_pad_oe_n = if_low.pin_oe_n;
  assign addr_upper_high_pad_drv = if_high.pin_out;
  assign addr_upper_high_pad_oe_n = if_high.pin_oe_n;
  assign port_group_timer_pad_drv = if_tmr.pin_out;
  assign port_group_timer_pad_oe_n = if_tmr.pin_oe_n;
  assign port_group_compare_pad_drv = if_cmp.pin_out;
  assign port_group_compare_pad_oe_n = if_cmp.pin_oe_n;
  assign port_group_pulse_pad_drv = if_pg.pin_out;
  assign port_group_pulse_pad_oe_n = if_pg.pin_oe_n;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_data_lo_bus;
    (ext_mode && !bus8_mode) |=> (data_hi_low_byte_pad_drv == $past(ext_wdata[7:0])) &&
      (data_hi_low_byte_pad_oe_n == {8{!$past(ext_wdata_drive)}});
  endproperty
  a_data_lo_bus: assert property (p_data_lo_bus) else $error("data low byte not on bus");

  property p_data_lo_port;
    bus8_mode |=> data_hi_low_byte_pad_drv == $past(if_two.port_dout);
  endproperty
  a_data_lo_port: assert property (p_data_lo_port) else $error("data low byte not port");

  property p_data_top_port;
    !ext_mode |=> (data_top_byte_pad_drv == $past(if_three.port_dout)) &&
      (data_top_byte_pad_oe_n == ~$past(if_three.port_dir));
  endproperty
  a_data_top_port: assert property (p_data_top_port) else $error("top data byte not port");

  property p_addr0_bus;
    ext_mode |=> (addr_byte0_pad_drv == $past(ext_addr[7:0])) && (addr_byte0_pad_oe_n == 8'h00);
  endproperty
  a_addr0_bus: assert property (p_addr0_bus) else $error("address byte zero not driven");

  property p_addr1_port;
    !ext_mode |=> addr_byte1_pad_oe_n == ~$past(if_five.port_dir);
  endproperty
  a_addr1_port: assert property (p_addr1_port) else $error("address byte one not port");

  property p_ahi_port;
    (!ext_mode || ahi_off) |=> addr_upper_low_pad_drv == $past(if_low.port_dout);
  endproperty
  a_ahi_port: assert property (p_ahi_port) else $error("address 16-20 not port");

  property p_atop_bus;
    (ext_mode && !atop_off) |=> (addr_upper_high_pad_drv == $past(ext_addr[23:21])) &&
      (addr_upper_high_pad_oe_n == 3'h0);
  endproperty
  a_atop_bus: assert property (p_atop_bus) else $error("address 21-23 not driven");

  property p_tmr_pin;
    1 |=> port_group_timer_pad_drv ==
      $past((if_tmr.func_sel & reload_timer_out) | (~if_tmr.func_sel & if_tmr.port_dout));
  endproperty
  a_tmr_pin: assert property (p_tmr_pin) else $error("timer pin value wrong");

  property p_cmp_dir;
    1 |=> port_group_compare_pad_oe_n == $past(~(if_cmp.func_sel | if_cmp.port_dir));
  endproperty
  a_cmp_dir: assert property (p_cmp_dir) else $error("compare pin direction wrong");

  property p_pg_pin;
    1 |=> port_group_pulse_pad_drv ==
      $past((if_pg.func_sel & pulse_gen_out) | (~if_pg.func_sel & if_pg.port_dout));
  endproperty
  a_pg_pin: assert property (p_pg_pin) else $error("pulse pin value wrong");
endmodule // bps_pin_share
`default_nettype wire

// file: sim/bps_ext_mem.sv
`timescale 1ns/1ps
`default_nettype none
// far side of the pins: driven pins loop back
module bps_ext_mem #(parameter int W = 58) (
  input wire logic aclk,
  input wire logic [W-1:0] drv,
  input wire logic [W-1:0] oe_n,
  output logic [W-1:0] val
);
  logic [W-1:0] last_q = '0;
  // remember what each pin last carried while driven; unknown enables are skipped
  always_ff @(posedge aclk) begin
    for (int i = 0; i < W; i++) begin
      if (oe_n[i] === 1'b0) begin
        last_q[i] <= drv[i];
      end
    end
  end
  // released pins show the opposite, so a stale read shows up
  assign val = (drv & ~oe_n) | (~last_q & oe_n);
endmodule // bps_ext_mem
`default_nettype wire

// file: sim/tb_bus_and_timer_pin_sharing.sv
`timescale 1ns/1ps
`default_nettype none
module tb_bus_and_timer_pin_sharing;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, ext_wdata_drive = 1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, compare_out = 8'hC3;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, pd_a = 32'h5AC3_3CA5, pr_a = 32'h0FF0_33CC;
  logic [31:0] pd_b = 32'h2D9C_A6B7, pr_b = 32'h1906_5A93;
  logic [3:0] s_axi_wstrb = 4'hF, reload_timer_out = 4'h9;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [23:0] ext_addr = 24'hA5_C3E1;
  logic [15:0] ext_wdata = 16'h3C96, ext_rdata;
  logic [5:0] pulse_gen_out = 6'h2D;
  logic [57:0] drv, oe_n, val;
  int failures = 0, comparisons = 0;
  // pin groups packed low to high in one vector
  bps_pin_share dut_u (.*,
    .data_hi_low_byte_pad_val(val[7:0]), .data_hi_low_byte_pad_drv(drv[7:0]), .data_hi_low_byte_pad_oe_n(oe_n[7:0]),
    .data_top_byte_pad_val(val[15:8]), .data_top_byte_pad_drv(drv[15:8]), .data_top_byte_pad_oe_n(oe_n[15:8]),
    .addr_byte0_pad_val(val[23:16]), .addr_byte0_pad_drv(drv[23:16]), .addr_byte0_pad_oe_n(oe_n[23:16]),
    .addr_byte1_pad_val(val[31:24]), .addr_byte1_pad_drv(drv[31:24]), .addr_byte1_pad_oe_n(oe_n[31:24]),
    .addr_upper_low_pad_val(val[36:32]), .addr_upper_low_pad_drv(drv[36:32]), .addr_upper_low_pad_oe_n(oe_n[36:32]),
    .addr_upper_high_pad_val(val[39:37]), .addr_upper_high_pad_drv(drv[39:37]), .addr_upper_high_pad_oe_n(oe_n[39:37]),
    .port_group_timer_pad_val(val[43:40]), .port_group_timer_pad_drv(drv[43:40]), .port_group_timer_pad_oe_n(oe_n[43:40]),
    .port_group_compare_pad_val(val[51:44]), .port_group_compare_pad_drv(drv[51:44]),
    .port_group_compare_pad_oe_n(oe_n[51:44]), .port_group_pulse_pad_val(val[57:52]),
    .port_group_pulse_pad_drv(drv[57:52]), .port_group_pulse_pad_oe_n(oe_n[57:52]));
  bps_ext_mem #(.W(58)) pins_u (.aclk(aclk), .drv(drv), .oe_n(oe_n), .val(val));
  // clock and watchdog
  initial forever #12.5 aclk = ~aclk;
  initial begin
    #200000;
    failures++;
    conclude();
  end
  task automatic ck(input logic [63:0] g, input logic [63:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw, w;
    aw = 1;
    w = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (aw | w) begin
      @(posedge aclk);
      if (s_axi_awready) aw = 0;
      if (s_axi_wready) w = 0;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    s_axi_bready <= 1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
    ck(s_axi_bresp, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
    ck(s_axi_rdata, d);
    ck(s_axi_rresp, r);
  endtask
  // expected pins: function where selected, port data and direction elsewhere
  task automatic cfg(input logic [3:0] m, input logic [17:0] en);
    logic [57:0] sel;
    sel = {en, {3{m[0] & ~m[3]}}, {5{m[0] & ~m[2]}}, {16{m[0]}}, {8{m[0]}}, {8{m[0] & ~m[1]}}};
    wr(bps_pkg::OFF_MODE, {28'h0, m}, bps_pkg::RESP_OKAY);
    wr(bps_pkg::OFF_OUT_EN, {14'h0, en}, bps_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    ck(drv, {(sel & {pulse_gen_out, compare_out, reload_timer_out, ext_addr, ext_wdata})
      | (~sel & {pd_b[29:24], pd_b[15:8], pd_b[19:16], pd_b[7:0], pd_a})});
    ck(oe_n, {(sel & {42'h0, {16{~ext_wdata_drive}}})
      | (~sel & ~{pr_b[29:24], pr_b[15:8], pr_b[19:16], pr_b[7:0], pr_a})});
  endtask
  task automatic t_ports;
    wr(bps_pkg::OFF_PDATA_A, pd_a, bps_pkg::RESP_OKAY);
    wr(bps_pkg::OFF_PDIR_A, pr_a, bps_pkg::RESP_OKAY);
    wr(bps_pkg::OFF_PDATA_B, pd_b, bps_pkg::RESP_OKAY);
    wr(bps_pkg::OFF_PDIR_B, pr_b, bps_pkg::RESP_OKAY);
    cfg(4'h0, 18'h0);
    // released pins never driven read high through the far side
    rd(bps_pkg::OFF_LEVEL_A, {(pd_a & pr_a) | ~pr_a}, bps_pkg::RESP_OKAY);
    rd(bps_pkg::OFF_LEVEL_B, {((pd_b & pr_b) | ~pr_b) & bps_pkg::B_MASK}, bps_pkg::RESP_OKAY);
    ck(ext_rdata, {(pd_a[15:0] & pr_a[15:0]) | ~pr_a[15:0]});
    $display("t_ports done");
  endtask
  task automatic t_bus;
    cfg(4'h7, 18'h0);
    ext_wdata_drive <= 0;
    cfg(4'h9, 18'h2_5A6C);
    // let the synchroniser catch up with the released data pins
    repeat (4) @(posedge aclk);
    ck(ext_rdata, {~ext_wdata[15:8], ~(pd_a[7:0] & pr_a[7:0])});
    $display("t_bus done");
  endtask
  task automatic t_refuse;
    wr(bps_pkg::OFF_LEVEL_A, 32'hFFFF_FFFF, bps_pkg::RESP_SLVERR);
    wr(8'h40, 32'hFFFF_FFFF, bps_pkg::RESP_SLVERR);
    rd(bps_pkg::OFF_MODE, 32'h0000_0009, bps_pkg::RESP_OKAY);
    rd(8'h40, 32'h0000_0000, bps_pkg::RESP_SLVERR);
    cfg(4'h8, 18'h3_FFFF);
    // one byte lane only: the other lanes keep their direction bits
    s_axi_wstrb <= 4'h2;
    wr(bps_pkg::OFF_PDIR_A, 32'h0000_0000, bps_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(bps_pkg::OFF_PDIR_A, pr_a & 32'hFFFF_00FF, bps_pkg::RESP_OKAY);
    $display("t_refuse done");
  endtask
  task automatic conclude;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // reset two cycles, one idle edge, then the tests
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_ports();
    t_bus();
    t_refuse();
    conclude();
  end
endmodule // tb_bus_and_timer_pin_sharing
`default_nettype wire
